/* logic/rtc_config_regs.v */
// Purpose: alarm2 day/date, countdown timer and power-management registers on ahb-lite
// Assumes: one 50 MHz clock; timer tick is a one-cycle enable from outside
// Notes:   every output is registered; the slave never inserts wait states
//
// Contract
// - select bit 6: 0 date, 1 day
// - bit 7 masks day/date from match
// - tens bits 5:4, units 3:0 compared
// - read-only count at 0x19/0x1a, reset zero
// - read/write reload at 0x1b/0x1c, reset zero
// - repeat mode reloads at zero, keeps counting
// - bit 3 enables battery detector
// - bit 2 threshold: 0 1.5V, 1 2.0V
// - threshold used only when manual bit 0
// - bit 1 backup select, only when manual 1
// - bits 7:4 reserved, control bits reset 0
// - manual low: automatic supply choice
// - manual backup honoured only if vcc below vbat
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rtc_defines.vh"

module rtc_config_regs #(
  parameter CNT_W = 16
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        timer_tick,
  input  wire [5:0]  cur_date,
  input  wire [2:0]  cur_day,
  input  wire        time_match,
  input  wire        auto_use_backup,
  input  wire        vcc_below_vbat,
  output reg         battery_detect_en,
  output reg         threshold_2v0,
  output reg         threshold_active,
  output reg         use_backup_supply,
  output reg         alarm2_hit,
  output reg         timer_expired,
  output reg         irq
);

  // ****************************************
  // ahb address phase capture
  // ****************************************
  reg        wr_pend_q;
  reg [7:0]  wr_idx_q;
  wire       addr_ok = hsel & hready & htrans[1];
  wire [7:0] a_idx   = haddr[9:2];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok)
        wr_idx_q <= a_idx;
    end
  end

  wire       wr_en = wr_pend_q;
  wire [7:0] wb    = hwdata[7:0];

  // ****************************************
  // configuration registers
  // ****************************************
  reg [7:0]       a2_q;
  reg [CNT_W-1:0] reload_q;
  reg [3:0]       pwr_q;
  reg [1:0]       tctrl_q;
  reg [1:0]       irq_en_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a2_q     <= `RTC_RST_BYTE;
      reload_q <= {CNT_W{1'b0}};
      pwr_q    <= `RTC_RST_PWR;
      tctrl_q  <= 2'h0;
      irq_en_q <= 2'h0;
    end else if (wr_en) begin
      case (wr_idx_q)
        `RTC_IDX_ALM2_DAYDATE: a2_q <= wb;
        `RTC_IDX_RELOAD_HIGH:  reload_q[15:8] <= wb;
        `RTC_IDX_RELOAD_LOW:   reload_q[7:0] <= wb;
        `RTC_IDX_POWER_MANAGEMENT_CONFIG:     pwr_q <= wb[3:0];
        `RTC_IDX_TMR_CTRL:     tctrl_q <= wb[1:0];
        `RTC_IDX_IRQ_ENABLE:   irq_en_q <= wb[1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // countdown timer
  // ****************************************
  reg [CNT_W-1:0] cnt_q;
  reg             cnt_zero_d;
  wire            run = tctrl_q[`RTC_TC_EN_BIT];
  wire            rep = tctrl_q[`RTC_TC_REPEAT_BIT];

  // count registers have no direct write path; a timer control write setting the enable while stopped, or repeat mode at zero, loads them from reload
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `RTC_RST_CNT;
    end else if (wr_en && wr_idx_q == `RTC_IDX_TMR_CTRL && wb[`RTC_TC_EN_BIT] && !run) begin
      cnt_q <= reload_q;
    end else if (run && timer_tick) begin
      if (cnt_q == {CNT_W{1'b0}}) begin
        if (rep)
          cnt_q <= reload_q;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  always @* begin
    cnt_zero_d = run & timer_tick & (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  end

  // ****************************************
  // alarm2 day/date match
  // ****************************************
  reg dd_ok_d;
  always @* begin
    if (a2_q[`RTC_A2_MASK_BIT])
      dd_ok_d = 1'b1;
    else if (a2_q[`RTC_A2_SEL_BIT])
      dd_ok_d = (a2_q[3:0] == {1'b0, cur_day}) && (a2_q[5:4] == 2'h0);
    else
      dd_ok_d = ({a2_q[5:4], a2_q[3:0]} == cur_date);
  end

  reg  match_q;
  wire alarm_ev = time_match & dd_ok_d & ~match_q;

  // ****************************************
  // interrupt status, set wins over clear
  // ****************************************
  reg [1:0] irq_st_q;
  wire [1:0] ev_set = {alarm_ev, cnt_zero_d};
  wire [1:0] clr = (wr_en && wr_idx_q == `RTC_IDX_IRQ_CLEAR) ? wb[1:0] : 2'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= 2'h0;
      match_q  <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~clr) | ev_set;
      match_q  <= time_match & dd_ok_d;
    end
  end

  // ****************************************
  // power-management decode and outputs
  // ****************************************
  wire manual = pwr_q[`RTC_PM_MANUAL_BIT];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      battery_detect_en <= 1'b0;
      threshold_2v0     <= 1'b0;
      threshold_active  <= 1'b0;
      use_backup_supply <= 1'b0;
      alarm2_hit        <= 1'b0;
      timer_expired     <= 1'b0;
      irq               <= 1'b0;
    end else begin
      battery_detect_en <= pwr_q[`RTC_PM_DETECT_BIT];
      threshold_2v0     <= pwr_q[`RTC_PM_POWER_FAIL_THRESHOLD_SELECT_BIT];
      threshold_active  <= ~manual;
      if (manual)
        use_backup_supply <= pwr_q[`RTC_PM_BACKUP_BIT] & vcc_below_vbat;
      else
        use_backup_supply <= auto_use_backup;
      alarm2_hit        <= alarm_ev;
      timer_expired     <= cnt_zero_d;
      irq               <= |(((irq_st_q & ~clr) | ev_set) & irq_en_q);
    end
  end

  // ****************************************
  // ahb read path, zero-wait, always okay
  // ****************************************
  reg [7:0] rd_d;
  always @* begin
    case (a_idx)
      `RTC_IDX_ALM2_DAYDATE: rd_d = a2_q;
      `RTC_IDX_CNT_HIGH:     rd_d = cnt_q[15:8];
      `RTC_IDX_CNT_LOW:      rd_d = cnt_q[7:0];
      `RTC_IDX_RELOAD_HIGH:  rd_d = reload_q[15:8];
      `RTC_IDX_RELOAD_LOW:   rd_d = reload_q[7:0];
      `RTC_IDX_POWER_MANAGEMENT_CONFIG:     rd_d = {4'h0, pwr_q};
      `RTC_IDX_TMR_CTRL:     rd_d = {6'h00, tctrl_q};
      `RTC_IDX_IRQ_STATUS:   rd_d = {6'h00, irq_st_q};
      `RTC_IDX_IRQ_ENABLE:   rd_d = {6'h00, irq_en_q};
      `RTC_IDX_CAL_STATUS:   rd_d = {6'h00, use_backup_supply, threshold_active};
      default:               rd_d = 8'h00;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite)
        hrdata <= {24'h00_0000, rd_d};
    end
  end

endmodule // rtc_config_regs

/* logic/rtc_defines.vh */
// Purpose: register offsets, field positions and reset values of the rtc config bank
// Assumes: byte-wide registers, each on its own aligned ahb word
// Notes:   definitions only
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
// ****************************************
// register word indices, decoded from haddr[9:2]
// ****************************************
`define RTC_IDX_ALM2_DAYDATE   8'h18
`define RTC_IDX_CNT_HIGH       8'h19
`define RTC_IDX_CNT_LOW        8'h1a
`define RTC_IDX_RELOAD_HIGH    8'h1b
`define RTC_IDX_RELOAD_LOW     8'h1c
`define RTC_IDX_POWER_MANAGEMENT_CONFIG       8'h1d
`define RTC_IDX_TMR_CTRL       8'h40
`define RTC_IDX_IRQ_STATUS     8'h41
`define RTC_IDX_IRQ_ENABLE     8'h42
`define RTC_IDX_IRQ_CLEAR      8'h43
`define RTC_IDX_CAL_STATUS     8'h44
// ****************************************
// fields
// ****************************************
`define RTC_A2_MASK_BIT        7
`define RTC_A2_SEL_BIT         6
`define RTC_PM_DETECT_BIT      3
`define RTC_PM_POWER_FAIL_THRESHOLD_SELECT_BIT        2
`define RTC_PM_BACKUP_BIT      1
`define RTC_PM_MANUAL_BIT      0
`define RTC_TC_EN_BIT          0
`define RTC_TC_REPEAT_BIT      1
`define RTC_IRQ_EXPIRE_BIT     0
`define RTC_IRQ_ALARM_BIT      1
// ****************************************
// reset values
// ****************************************
`define RTC_RST_BYTE           8'h00
`define RTC_RST_PWR            4'h0
`define RTC_RST_CNT            16'h0000
`endif

/* dv/rtc_config_regs_chk.sv */
// Purpose: port assertions for rtc_config_regs
// Assumes: outputs are registered one cycle after their cause
// Notes:   sees the top module ports only
`timescale 1ns/1ps
module rtc_config_regs_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timer_tick,
  input wire logic        time_match,
  input wire logic        auto_use_backup,
  input wire logic        vcc_below_vbat,
  input wire logic        battery_detect_en,
  input wire logic        threshold_2v0,
  input wire logic        threshold_active,
  input wire logic        use_backup_supply,
  input wire logic        alarm2_hit,
  input wire logic        timer_expired
);
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] wr_age_q;
  // age of the last write lets config changes be tied to a bus write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_age_q <= 3'h7;
    else if (hsel && hready && htrans[1] && hwrite) wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
  sequence req_s; hsel && hready && htrans[1]; endsequence
  sequence ok_s; hreadyout && !hresp; endsequence
  bus_answer_a: assert property (req_s |=> ok_s)
    else $error("bus answer not ready okay");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  auto_supply_a: assert property (threshold_active |-> use_backup_supply == $past(auto_use_backup))
    else $error("automatic supply choice not followed");
  manual_backup_a: assert property (!threshold_active && use_backup_supply |-> $past(vcc_below_vbat))
    else $error("backup used while vcc not below battery");
  expiry_tick_a: assert property (timer_expired |-> $past(timer_tick))
    else $error("expiry without a tick");
  alarm_cause_a: assert property (alarm2_hit |-> $past(time_match))
    else $error("alarm hit without time match");
  alarm_pulse_a: assert property (alarm2_hit |=> !alarm2_hit)
    else $error("alarm hit longer than one cycle");
  cfg_by_write_a: assert property (!$stable({battery_detect_en, threshold_2v0}) |-> wr_age_q <= 3'h3)
    else $error("config output changed without a write");
endmodule // rtc_config_regs_chk
bind rtc_config_regs rtc_config_regs_chk rtc_config_regs_chk_i (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .timer_tick, .time_match, .auto_use_backup,
  .vcc_below_vbat, .battery_detect_en, .threshold_2v0, .threshold_active, .use_backup_supply,
  .alarm2_hit, .timer_expired);

/* dv/tb.sv */
// Purpose: self-checking bench for rtc_config_regs
// Assumes: zero-wait ahb slave, hready fed back from hreadyout
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "rtc_defines.vh"
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, timer_tick, time_match;
  logic        auto_use_backup, vcc_below_vbat, battery_detect_en, threshold_2v0;
  logic        threshold_active, use_backup_supply, alarm2_hit, timer_expired, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cur_day;
  logic [5:0]  cur_date;
  int          error_cnt = 0, n_compared = 0, cyc = 0, hit_n = 0, exp_n = 0;
  rtc_config_regs rtc_config_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer_tick, .cur_date, .cur_day,
    .time_match, .auto_use_backup, .vcc_below_vbat, .battery_detect_en, .threshold_2v0,
    .threshold_active, .use_backup_supply, .alarm2_hit, .timer_expired, .irq);
  // ****************
  // helpers
  // ****************
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // pulses are counted so a task can never miss one between its own waits
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (alarm2_hit === 1'b1) hit_n <= hit_n + 1;
    if (timer_expired === 1'b1) exp_n <= exp_n + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(logic w, logic [7:0] idx, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // sel 0 pulses the timer tick, sel 1 the time match; a ref port cannot take a nonblocking write
  task automatic pulse(int sel);
    if (sel == 0) timer_tick <= 1'b1;
    else time_match <= 1'b1;
    @(posedge hclk);
    timer_tick <= 1'b0;
    time_match <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    for (int i = 'h18; i <= 'h1d; i++) begin
      bus(1'b0, 8'(i), 32'h0);
      chk("reset reg", rd, 32'h0);
    end
    bus(1'b0, 8'h3f, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_power;
    vcc_below_vbat <= 1'b1;
    bus(1'b1, `RTC_IDX_POWER_MANAGEMENT_CONFIG, 32'hff);
    bus(1'b0, `RTC_IDX_POWER_MANAGEMENT_CONFIG, 32'h0);
    chk("pm read", rd, 32'h0f);
    chk("detect on", battery_detect_en, 1'b1);
    chk("thr 2v0", threshold_2v0, 1'b1);
    chk("thr ignored", threshold_active, 1'b0);
    chk("backup", use_backup_supply, 1'b1);
    vcc_below_vbat <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("backup refused", use_backup_supply, 1'b0);
    auto_use_backup <= 1'b1;
    bus(1'b1, `RTC_IDX_POWER_MANAGEMENT_CONFIG, 32'h04);
    repeat (3) @(posedge hclk);
    chk("thr used", threshold_active, 1'b1);
    chk("auto choice", use_backup_supply, 1'b1);
    chk("detect off", battery_detect_en, 1'b0);
    bus(1'b1, `RTC_IDX_POWER_MANAGEMENT_CONFIG, 32'h0);
    repeat (3) @(posedge hclk);
    chk("thr 1v5", threshold_2v0, 1'b0);
  endtask
  task automatic t_timer;
    int n;
    bus(1'b1, `RTC_IDX_RELOAD_LOW, 32'h02);
    bus(1'b0, `RTC_IDX_RELOAD_LOW, 32'h0);
    chk("reload read", rd, 32'h02);
    bus(1'b1, `RTC_IDX_TMR_CTRL, 32'h03);
    bus(1'b1, `RTC_IDX_CNT_LOW, 32'h55);
    bus(1'b0, `RTC_IDX_CNT_LOW, 32'h0);
    chk("count kept", rd, 32'h02);
    n = exp_n;
    pulse(0);
    bus(1'b0, `RTC_IDX_CNT_LOW, 32'h0);
    chk("count step", rd, 32'h01);
    pulse(0);
    chk("expired", exp_n - n, 1);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, `RTC_IDX_IRQ_ENABLE, 32'h01);
    bus(1'b0, `RTC_IDX_CNT_HIGH, 32'h0);
    chk("irq raised", irq, 1'b1);
    bus(1'b1, `RTC_IDX_IRQ_CLEAR, 32'h01);
    bus(1'b0, `RTC_IDX_CNT_HIGH, 32'h0);
    chk("irq cleared", irq, 1'b0);
    pulse(0);
    bus(1'b0, `RTC_IDX_CNT_LOW, 32'h0);
    chk("reloaded", rd, 32'h02);
  endtask
  task automatic t_alarm;
    logic [7:0] av[4] = '{8'h15, 8'h15, 8'h43, 8'h95};
    logic [5:0] dt[4] = '{6'h15, 6'h14, 6'h14, 6'h14};
    int ex[4] = '{1, 0, 1, 1};
    int n;
    for (int i = 0; i < 4; i++) begin
      cur_date <= dt[i];
      cur_day <= 3'h3;
      bus(1'b1, `RTC_IDX_ALM2_DAYDATE, {24'h0, av[i]});
      bus(1'b0, `RTC_IDX_ALM2_DAYDATE, 32'h0);
      chk("alarm reg", rd, {24'h0, av[i]});
      n = hit_n;
      pulse(1);
      chk("alarm hit", hit_n - n, ex[i]);
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timer_tick = 1'b0;
    cur_date = 6'h0;
    cur_day = 3'h0;
    time_match = 1'b0;
    auto_use_backup = 1'b0;
    vcc_below_vbat = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_power;
    t_timer;
    t_alarm;
    wrap_up;
  end
endmodule // tb
